// ### hdl/audio_port_pkg.sv
// constants shared by the audio serial port controller and its queue
`default_nettype none
package audio_port_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CLK   = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_RAW   = 8'h10;
  localparam logic [7:0] OFS_CLR   = 8'h14;
  localparam logic [7:0] OFS_QUEUE = 8'h18;
  ////////////////////////////////////////////////////////////////////////////
  // audio_port_control field positions
  localparam int B_START = 0;
  localparam int B_MUTE  = 1;
  localparam int B_MONO  = 2;
  localparam int B_TRS   = 3;
  localparam int B_MS    = 4;
  localparam int B_FMT   = 5;
  localparam int B_FLUSH = 7;
  localparam int B_DL    = 10;
  localparam int B_TH    = 12;
  localparam int B_EN    = 15;
  localparam int B_CHLEN = 16;
  // audio_port_clock_config field positions
  localparam int B_MCDIV = 0;
  localparam int B_MCOEN = 3;
  localparam int B_MCSEL = 4;
  localparam int B_BCDIV = 8;
  // status and raw flag field positions
  localparam int B_RIGHT = 1;
  localparam int B_THF   = 6;
  localparam int B_FULL  = 10;
  localparam int B_EMPTY = 11;
  localparam int B_LVL   = 12;
  localparam int B_UDF   = 4;
  localparam int B_OVF   = 5;
  localparam int B_THI   = 6;
  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [4:0] RST_CHLEN = 5'h1f;
  localparam logic [2:0] RST_TH    = 3'h3;
  localparam logic [1:0] RST_DL    = 2'h1;
  localparam logic [7:0] RST_BCDIV = 8'h01;
  localparam logic [2:0] RST_MCDIV = 3'h0;
  // queue shape
  localparam logic [3:0] QUEUE_DEPTH = 4'h8;
  // frame formats
  localparam logic [1:0] FMT_STD   = 2'h0;
  localparam logic [1:0] FMT_LEFT  = 2'h1;
  localparam logic [1:0] FMT_RIGHT = 2'h2;
endpackage : audio_port_pkg
`default_nettype wire

// ### hdl/audio_queue.sv
// eight word by 32 bit sample queue with flush
`timescale 1ns/1ps
`default_nettype none
module audio_queue
  import audio_port_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // control
  input  wire logic        flush_i,
  input  wire logic        push_i,
  input  wire logic [31:0] push_data_i,
  input  wire logic        pop_i,
  // state
  output logic      [31:0] head_o,
  output logic      [3:0]  level_o,
  output logic             full_o,
  output logic             empty_o
);
  typedef struct packed {
    logic [7:0][31:0] mem;
    logic [2:0]       wr;
    logic [2:0]       rd;
    logic [3:0]       lvl;
  } queue_t;

  queue_t r;
  queue_t next_r;
  logic   do_pop;
  logic   do_push;

  ////////////////////////////////////////////////////////////////////////////
  // push and pop, full writes dropped unless a pop frees a word, empty pops ignored
  always_comb begin
    next_r  = r;
    do_pop  = pop_i && (r.lvl != 4'h0);
    do_push = push_i && ((r.lvl != QUEUE_DEPTH) || do_pop);
    if (do_pop) begin
      next_r.rd = r.rd + 3'h1;
    end
    if (do_push) begin
      next_r.mem[r.wr] = push_data_i;
      next_r.wr        = r.wr + 3'h1;
    end
    next_r.lvl = r.lvl + {3'h0, do_push} - {3'h0, do_pop};
    if (flush_i) begin
      next_r = '0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // status views
  assign head_o  = r.mem[r.rd];
  assign level_o = r.lvl;
  assign full_o  = (r.lvl == QUEUE_DEPTH);
  assign empty_o = (r.lvl == 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_flush_empties: assert property (@(posedge clk_i) disable iff (rst_i)
    flush_i |=> (level_o == 4'h0) && empty_o)
    else $error("flush did not empty the queue");
  a_full_drops: assert property (@(posedge clk_i) disable iff (rst_i)
    (full_o && push_i && !pop_i && !flush_i) |=> full_o && $stable(r.mem))
    else $error("write into full queue was not dropped");
  a_level_range: assert property (@(posedge clk_i) disable iff (rst_i)
    (level_o <= QUEUE_DEPTH) && (empty_o == (level_o == 4'h0)))
    else $error("queue level out of range");
endmodule : audio_queue
`default_nettype wire

// ### hdl/audio_serial_port_controller.sv
// audio serial port: wishbone registers, clock tree, serial engine
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - master_slave_select 0 makes bit clock and word select; 1 takes them.
// - data pin drives when transmitting, is sampled when receiving.
// - sample width codes give 8, 16, 24 or 32 bits; reset 16.
// - slot lasts slot_bit_count_field plus one bit clocks; reset 32.
// - format 00 standard, 01 left justified, 10 right justified.
// - mono/stereo bit: 0 stereo left and right, 1 mono.
// - mute forces the serial data output low.
// - start bit runs the link, clearing it stops; set it last.
// - port enable hands clock and word select pins to the port.
// - flush bit empties the queue and clears itself.
// - queue holds eight 32-bit words for transmit or receive.
// - threshold field 0 to 7, reset 3, raises a threshold event.
// - master bit clock is master clock over 2n+2, over n+1 when the master divider is 0; divider resets 1.
// - master clock source: system clock or the external pin.
// - master clock is source over 2 for 0, source over 2n otherwise.
// - master clock output enable drives the pin only when set.
// - queue level reports 0 to 8 occupied words.
// - full writes dropped unless a pop frees a word in the same cycle, empty reads give zero, full and empty flags.
// - threshold flag: level below as transmitter, above as receiver.
// - overflow and underflow latch, cleared by writing one.
module audio_serial_port_controller
  import audio_port_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // master clock pin
  input  wire logic        master_clock_pin_i,
  output logic             master_clock_pin_o,
  output logic             master_clock_pin_oe_o,
  // bit clock pin
  input  wire logic        bit_clock_pin_i,
  output logic             bit_clock_pin_o,
  output logic             bit_clock_pin_oe_o,
  // word select pin
  input  wire logic        word_select_pin_i,
  output logic             word_select_pin_o,
  output logic             word_select_pin_oe_o,
  // serial data pin
  input  wire logic        serial_data_pin_i,
  output logic             serial_data_pin_o,
  output logic             serial_data_pin_oe_o
);
  typedef enum logic {IDLE, RUN} run_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic        start, mute, mono, tx_rx_direction_select, ms, en;
    logic [1:0]  fmt, dl;
    logic [2:0]  th;
    logic [4:0]  chlen;
    logic [7:0]  bcdiv;
    logic        mcsel, mcoen;
    logic [2:0]  mcdiv;
    logic        ovf, udf, thi, thf_prev;
    run_t        run;
    logic [2:0]  mc_cnt;
    logic        mc_lvl, mc_prev;
    logic [7:0]  bc_cnt;
    logic        bclk, bc_prev, ws, ws_last, right;
    logic [4:0]  k;
    logic [5:0]  p_cur;
    logic [1:0]  idx;
    logic [31:0] tx_sh, tx_hold, rx_sh, rx_asm;
    logic        sd, sd_oe, mc_oe, bc_oe, ws_oe, rx_on;
  } state_t;

  state_t      r;
  state_t      next_r;
  logic        q_flush, q_push, q_pop;
  logic [31:0] q_data, q_head;
  logic [3:0]  q_lvl;
  logic        q_full, q_empty;
  logic        req, thf, src_tick, mc_tick, brise, bfall, ws_in, need;
  logic [31:0] m, wv, word, aligned, rxv;
  logic [5:0]  wbits, slen, off, shamt;
  logic [4:0]  kk;
  logic [6:0]  t;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [5:0] sample_bits(input logic [1:0] dl);
    logic [2:0] n;
    n = {1'b0, dl} + 3'h1;
    return {n, 3'h0};
  endfunction : sample_bits

  function automatic logic [1:0] last_idx(input logic [1:0] dl);
    return (dl == 2'h0) ? 2'h3 : ((dl == 2'h1) ? 2'h1 : 2'h0);
  endfunction : last_idx

  function automatic logic [31:0] ctrl_word(input state_t s);
    logic [31:0] v;
    v = '0;
    v[B_START] = s.start;
    v[B_MUTE] = s.mute;
    v[B_MONO] = s.mono;
    v[B_TRS] = s.tx_rx_direction_select;
    v[B_MS] = s.ms;
    v[B_FMT+:2] = s.fmt;
    v[B_DL+:2] = s.dl;
    v[B_TH+:3] = s.th;
    v[B_EN] = s.en;
    v[B_CHLEN+:5] = s.chlen;
    return v;
  endfunction : ctrl_word

  function automatic logic [31:0] clk_word(input state_t s);
    logic [31:0] v;
    v = '0;
    v[B_MCDIV+:3] = s.mcdiv;
    v[B_MCOEN] = s.mcoen;
    v[B_MCSEL] = s.mcsel;
    v[B_BCDIV+:8] = s.bcdiv;
    return v;
  endfunction : clk_word

  ////////////////////////////////////////////////////////////////////////////
  // sample queue
  audio_queue audio_queue_inst (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (q_flush),
    .push_i      (q_push),
    .push_data_i (q_data),
    .pop_i       (q_pop),
    .head_o      (q_head),
    .level_o     (q_lvl),
    .full_o      (q_full),
    .empty_o     (q_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r  = r;
    q_flush = 1'b0;
    q_push  = 1'b0;
    q_pop   = 1'b0;
    q_data  = '0;
    word    = '0;
    aligned = '0;
    rxv     = '0;
    t       = '0;
    off     = '0;
    kk      = r.k;
    need    = 1'b0;
    src_tick = 1'b0;
    mc_tick = 1'b0;
    brise   = 1'b0;
    bfall   = 1'b0;
    m  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wv = '0;
    req = cyc_i && stb_i && !r.ack;
    wbits = sample_bits(r.dl);
    slen  = 6'({1'b0, r.chlen} + 6'h1);
    shamt = 6'(r.idx * wbits);
    thf = r.tx_rx_direction_select ? (q_lvl > {1'b0, r.th}) : (q_lvl < {1'b0, r.th});
    ws_in = r.ms ? word_select_pin_i : r.ws;
    next_r.ack = req;
    next_r.rdat = '0;
    // bus writes and reads, side effects on the acking edge
    if (req && we_i) begin
      case (adr_i)
        OFS_CTRL: begin
          wv = (ctrl_word(r) & ~m) | (dat_i & m);
          next_r.start = wv[B_START];
          next_r.mute  = wv[B_MUTE];
          next_r.mono  = wv[B_MONO];
          next_r.tx_rx_direction_select   = wv[B_TRS];
          next_r.ms    = wv[B_MS];
          next_r.fmt   = wv[B_FMT+:2];
          next_r.dl    = wv[B_DL+:2];
          next_r.th    = wv[B_TH+:3];
          next_r.en    = wv[B_EN];
          next_r.chlen = wv[B_CHLEN+:5];
          q_flush = dat_i[B_FLUSH] && sel_i[0];
        end
        OFS_CLK: begin
          wv = (clk_word(r) & ~m) | (dat_i & m);
          next_r.mcdiv = wv[B_MCDIV+:3];
          next_r.mcoen = wv[B_MCOEN];
          next_r.mcsel = wv[B_MCSEL];
          next_r.bcdiv = wv[B_BCDIV+:8];
        end
        OFS_CLR: begin
          wv = dat_i & m;
          if (wv[B_THI]) next_r.thi = 1'b0;
          if (wv[B_OVF]) next_r.ovf = 1'b0;
          if (wv[B_UDF]) next_r.udf = 1'b0;
        end
        OFS_QUEUE: begin
          if (!r.tx_rx_direction_select) begin
            q_push = 1'b1;
            q_data = dat_i;
            if (q_full) next_r.ovf = 1'b1;
          end
        end
        default: ;
      endcase
    end else if (req) begin
      case (adr_i)
        OFS_CTRL: next_r.rdat = ctrl_word(r);
        OFS_CLK:  next_r.rdat = clk_word(r);
        OFS_STAT: begin
          next_r.rdat[B_LVL+:4] = q_lvl;
          next_r.rdat[B_EMPTY]  = q_empty;
          next_r.rdat[B_FULL]   = q_full;
          next_r.rdat[B_THF]    = thf;
          next_r.rdat[B_RIGHT]  = r.right;
        end
        OFS_RAW: begin
          next_r.rdat[B_THI] = r.thi;
          next_r.rdat[B_OVF] = r.ovf;
          next_r.rdat[B_UDF] = r.udf;
        end
        OFS_QUEUE: begin
          if (r.tx_rx_direction_select) begin
            q_pop = 1'b1;
            next_r.rdat = q_empty ? 32'h0 : q_head;
            if (q_empty) next_r.udf = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // threshold crossing latches its event
    next_r.thf_prev = thf;
    if (thf && !r.thf_prev) next_r.thi = 1'b1;
    // master clock from system clock or external pin edge
    next_r.mc_prev = master_clock_pin_i;
    src_tick = r.mcsel ? (master_clock_pin_i && !r.mc_prev) : 1'b1;
    if (r.en && src_tick) begin
      if (r.mcdiv == 3'h0) begin
        mc_tick = 1'b1;
        next_r.mc_lvl = !r.mc_lvl;
      end else if (r.mc_cnt == r.mcdiv - 3'h1) begin
        next_r.mc_cnt = 3'h0;
        next_r.mc_lvl = !r.mc_lvl;
        mc_tick = !r.mc_lvl;
      end else begin
        next_r.mc_cnt = r.mc_cnt + 3'h1;
      end
    end
    // bit clock edges, made here or seen on the pin
    next_r.bc_prev = bit_clock_pin_i;
    if (r.ms) begin
      brise = bit_clock_pin_i && !r.bc_prev;
      bfall = !bit_clock_pin_i && r.bc_prev;
    end else if (mc_tick && r.run == RUN) begin
      if (r.bc_cnt == r.bcdiv) begin
        next_r.bc_cnt = 8'h0;
        next_r.bclk = !r.bclk;
        brise = !r.bclk;
        bfall = r.bclk;
      end else begin
        next_r.bc_cnt = r.bc_cnt + 8'h1;
      end
    end
    case (r.run)
      IDLE: begin
        next_r.bclk = 1'b0;
        next_r.bc_cnt = 8'h0;
        next_r.ws = 1'b1;
        next_r.ws_last = ws_in;
        next_r.right = 1'b1;
        next_r.k = r.chlen;
        next_r.p_cur = 6'h3f;
        next_r.idx = 2'h0;
        next_r.rx_asm = '0;
        next_r.rx_on = 1'b0;
        next_r.sd = 1'b0;
        if (r.en && r.start) next_r.run = RUN;
      end
      RUN: begin
        if (!(r.en && r.start)) next_r.run = IDLE;
        if (bfall) begin
          // slot counter, word select flips at slot start
          if (r.ms && ws_in != r.ws_last) begin
            kk = 5'h0; // slot opens at the word select change
            next_r.right = ws_in;
          end else if (r.k == r.chlen) begin
            kk = 5'h0;
            if (!r.ms) begin
              next_r.ws = !r.ws;
              next_r.right = !r.ws;
            end
          end else begin
            kk = r.k + 5'h1;
          end
          next_r.k = kk;
          next_r.ws_last = ws_in;
          // msb offset per format
          case (r.fmt)
            FMT_STD:   off = 6'h1;
            FMT_RIGHT: off = slen - wbits;
            default:   off = 6'h0;
          endcase
          t = {2'h0, kk} + {1'b0, slen} - {1'b0, off};
          if (t >= {1'b0, slen}) t = t - {1'b0, slen};
          next_r.p_cur = t[5:0];
          need = !r.mono || !next_r.right;
          if (!r.tx_rx_direction_select) begin
            if (t[5:0] == 6'h0) begin
              if (need) begin
                if (r.idx == 2'h0) begin
                  q_pop = 1'b1;
                  word = q_empty ? 32'h0 : q_head;
                  if (q_empty) next_r.udf = 1'b1;
                  next_r.tx_hold = word;
                end else begin
                  word = r.tx_hold;
                end
                aligned = (word >> shamt) << (6'd32 - wbits);
                next_r.idx = (r.idx == last_idx(r.dl)) ? 2'h0 : r.idx + 2'h1;
              end
              next_r.sd = aligned[31];
              next_r.tx_sh = aligned << 1;
            end else if (t[5:0] < wbits) begin
              next_r.sd = r.tx_sh[31];
              next_r.tx_sh = r.tx_sh << 1;
            end else begin
              next_r.sd = 1'b0;
            end
          end
        end
        // receive side samples on the rising edge
        if (brise && r.tx_rx_direction_select && r.p_cur < wbits && (!r.mono || !r.right)) begin
          rxv = {r.rx_sh[30:0], serial_data_pin_i};
          next_r.rx_sh = rxv;
          if (r.p_cur == 6'h0) next_r.rx_on = 1'b1; // a whole sample has begun
          if (r.p_cur == wbits - 6'h1 && r.rx_on) begin
            rxv = (rxv << (6'd32 - wbits)) >> (6'd32 - wbits);
            wv = r.rx_asm | (rxv << shamt);
            if (r.idx == last_idx(r.dl)) begin
              q_push = 1'b1;
              q_data = wv;
              if (q_full) next_r.ovf = 1'b1;
              next_r.rx_asm = '0;
              next_r.idx = 2'h0;
            end else begin
              next_r.rx_asm = wv;
              next_r.idx = r.idx + 2'h1;
            end
          end
        end
      end
      default: next_r.run = IDLE;
    endcase
    if (next_r.mute || next_r.tx_rx_direction_select) next_r.sd = 1'b0;
    // pin ownership
    next_r.bc_oe = r.en && !r.ms;
    next_r.ws_oe = r.en && !r.ms;
    next_r.mc_oe = r.en && r.mcoen;
    next_r.sd_oe = r.en && !r.tx_rx_direction_select;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r       <= '0;
      r.dl    <= RST_DL;
      r.chlen <= RST_CHLEN;
      r.th    <= RST_TH;
      r.bcdiv <= RST_BCDIV;
      r.mcdiv <= RST_MCDIV;
      r.ws    <= 1'b1;
      r.right <= 1'b1;
      r.p_cur <= 6'h3f;
      r.run   <= IDLE;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign dat_o                 = r.rdat;
  assign ack_o                 = r.ack;
  assign master_clock_pin_o    = r.mc_lvl;
  assign master_clock_pin_oe_o = r.mc_oe;
  assign bit_clock_pin_o       = r.bclk;
  assign bit_clock_pin_oe_o    = r.bc_oe;
  assign word_select_pin_o     = r.ws;
  assign word_select_pin_oe_o  = r.ws_oe;
  assign serial_data_pin_o     = r.sd;
  assign serial_data_pin_oe_o  = r.sd_oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_mute_data_low: assert property (@(posedge clk_i) disable iff (rst_i)
    r.mute |-> !serial_data_pin_o)
    else $error("data driven while muted");
  a_master_pins_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.en && !r.ms) |=> bit_clock_pin_oe_o && word_select_pin_oe_o)
    else $error("master pins not driven");
  a_slave_pins_float: assert property (@(posedge clk_i) disable iff (rst_i)
    r.ms |=> !bit_clock_pin_oe_o && !word_select_pin_oe_o)
    else $error("slave drives clock pins");
  a_rx_data_float: assert property (@(posedge clk_i) disable iff (rst_i)
    r.tx_rx_direction_select |=> !serial_data_pin_oe_o && !serial_data_pin_o)
    else $error("receiver drives data pin");
  a_mclk_oe_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (!r.mcoen || !r.en) |=> !master_clock_pin_oe_o)
    else $error("master clock pin driven while disabled");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_bus_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && we_i && adr_i == OFS_QUEUE && !r.tx_rx_direction_select && q_full) |=> r.ovf)
    else $error("overflow not latched");
  a_reset_fields: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> r.dl == RST_DL && r.chlen == RST_CHLEN && r.th == RST_TH)
    else $error("control fields wrong after reset");
  a_idle_ws_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.run == IDLE && !r.start) |=> word_select_pin_o && !bit_clock_pin_o)
    else $error("link not stopped while start clear");
endmodule : audio_serial_port_controller
`default_nettype wire

// ### tb/audio_codec_model.sv
// far-end audio converter model: captures one stereo frame, feeds receive data
`timescale 1ns/1ps
`default_nettype none
module audio_codec_model (
  // clock and pins
  input  wire logic        clk_i,
  input  wire logic        bit_clock_i,
  input  wire logic        word_select_i,
  input  wire logic        serial_data_i,
  // control and results
  input  wire logic        send_ones_i,
  input  wire logic        slave_i,
  output logic             bit_clock_o,
  output logic             word_select_o,
  output logic             serial_data_o,
  output logic      [15:0] left_o,
  output logic      [15:0] right_o,
  output logic             got_o
);
  logic        prev_b;
  logic        ws_d;
  logic        have_l;
  logic [15:0] shl;
  logic [15:0] shr;
  logic [6:0]  cnt;
  logic        bc;
  initial begin
    {prev_b, have_l, got_o, shl, shr, left_o, right_o} = '0;
    {cnt, bit_clock_o, word_select_o} = '0;
    ws_d = 1'b1; // word select idles high: no false slot edge at the first rise
    serial_data_o = 1'b0;
  end
  // far end owns bit clock and word select in slave mode: 4 clk a bit, 16 bit slots
  always @(posedge clk_i) begin
    cnt           <= slave_i ? cnt + 7'h1 : 7'h0;
    bit_clock_o   <= slave_i && cnt[1];
    word_select_o <= slave_i && cnt[6];
  end
  assign bc = slave_i ? bit_clock_o : bit_clock_i;
  // sample on bit clock rise; bits belong to the slot of the previous word select
  always @(posedge clk_i) begin
    prev_b <= bc;
    if (bc && !prev_b) begin
      ws_d <= word_select_i;
      if (!ws_d) shl <= {shl[14:0], serial_data_i};
      else shr <= {shr[14:0], serial_data_i};
      if (!ws_d && word_select_i && !have_l) begin
        left_o <= {shl[14:0], serial_data_i};
        have_l <= 1'b1;
      end
      if (ws_d && !word_select_i && have_l && !got_o) begin
        right_o <= {shr[14:0], serial_data_i};
        got_o   <= 1'b1;
      end
    end
    // change data after the bit clock falls; toggle when not sending
    if (!bc && prev_b) serial_data_o <= send_ones_i ? 1'b1 : ~serial_data_o;
  end
endmodule : audio_codec_model
`default_nettype wire

// ### tb/test_audio_serial_port_controller.sv
// self-checking bench for the audio serial port controller
`timescale 1ns/1ps
`default_nettype none
module test_audio_serial_port_controller;
  import audio_port_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ones = 0, slave = 0;
  logic [7:0]  adr_i = '0;
  logic [3:0]  sel_i = '0;
  logic [31:0] dat_i = '0, dat_o, q;
  logic ack_o, mco, mcoe, bco, bcoe, wso, wsoe, sdo, sdoe, sd_far, got, mbc, mws;
  logic [15:0] left, right;
  int fails = 0, n_tests = 0;
  always #2 clk_i = ~clk_i;
  audio_serial_port_controller audio_serial_port_controller_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .master_clock_pin_i(mbc), .master_clock_pin_o(mco),
    .master_clock_pin_oe_o(mcoe), .bit_clock_pin_i(mbc), .bit_clock_pin_o(bco),
    .bit_clock_pin_oe_o(bcoe), .word_select_pin_i(mws), .word_select_pin_o(wso),
    .word_select_pin_oe_o(wsoe), .serial_data_pin_i(sd_far), .serial_data_pin_o(sdo),
    .serial_data_pin_oe_o(sdoe));
  audio_codec_model audio_codec_model_inst (.clk_i(clk_i), .bit_clock_i(bco),
    .word_select_i(wso), .serial_data_i(sdo), .send_ones_i(ones), .serial_data_o(sd_far),
    .slave_i(slave), .bit_clock_o(mbc), .word_select_o(mws),
    .left_o(left), .right_o(right), .got_o(got));
  ////////////////////////////////////////////////////////////////////////////
  // compare, bus cycle and closing tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (n >= 50) fails++;
  endtask : wb
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    wb(0, OFS_CTRL, 0); chk("control", 32'h001f3400, q);
    wb(0, OFS_CLK, 0); chk("clock", 32'h00000100, q);
    wb(0, OFS_STAT, 0); chk("status", 32'h00000842, q);
    wb(0, 8'h3c, 0); chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask : t_reset
  task automatic t_queue;
    for (int i = 0; i < 9; i++) wb(1, OFS_QUEUE, i);
    wb(0, OFS_STAT, 0); chk("full status", 32'h00008402, q);
    wb(0, OFS_RAW, 0); chk("overflow", 32'h20, q & 32'h20);
    wb(1, OFS_CLR, 32'h20); wb(0, OFS_RAW, 0); chk("ovf clear", 32'h0, q & 32'h20);
    wb(1, OFS_CTRL, 32'h001f3480); wb(0, OFS_STAT, 0); chk("flushed", 32'h00000842, q);
    wb(0, OFS_CTRL, 0); chk("flush bit", 32'h001f3400, q);
    wb(1, OFS_CTRL, 32'h001f3408); wb(0, OFS_QUEUE, 0); chk("empty read", 32'h0, q);
    wb(0, OFS_RAW, 0); chk("underflow", 32'h10, q & 32'h10);
    wb(1, OFS_CTRL, 32'h001f3400); wb(1, OFS_QUEUE, 1); wb(1, OFS_QUEUE, 2);
    wb(0, OFS_STAT, 0); chk("below th", 32'h00002042, q);
    wb(1, OFS_QUEUE, 3); wb(1, OFS_QUEUE, 4);
    wb(0, OFS_STAT, 0); chk("above th", 32'h00004002, q);
    wb(1, OFS_CTRL, 32'h001f3480);
    $display("test queue done");
  endtask : t_queue
  task automatic t_tx;
    int n, m;
    logic p;
    wb(1, OFS_CLK, 32'h00000008); wb(1, OFS_QUEUE, 32'h1234abcd); wb(1, OFS_QUEUE, 32'h1234abcd);
    wb(1, OFS_CTRL, 32'h000fb401);
    n = 0;
    while (got !== 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    chk("left", 32'habcd, {16'h0, left});
    chk("right", 32'h1234, {16'h0, right});
    chk("pin enables", 32'hf, {28'h0, mcoe, bcoe, wsoe, sdoe});
    for (int i = 0; i < 4; i++) wb(1, OFS_QUEUE, 32'hffffffff);
    wb(1, OFS_CTRL, 32'h000fb403);
    repeat (3) @(posedge clk_i);
    n = 0;
    m = 0;
    p = mco;
    repeat (200) begin
      @(posedge clk_i);
      n += sdo;
      m += (mco != p);
      p = mco;
    end
    chk("muted ones", 32'h0, n);
    chk("master clock edges", 32'hc8, m);
    wb(1, OFS_CTRL, 32'h000f3400);
    repeat (3) @(posedge clk_i);
    n = 0;
    repeat (20) begin
      @(posedge clk_i);
      n += bco;
    end
    chk("stopped clock", 32'h0, n);
    $display("test transmit done");
  endtask : t_tx
  task automatic t_rx;
    int n;
    ones <= 1'b1;
    wb(1, OFS_CTRL, 32'h000f3480); wb(1, OFS_CTRL, 32'h000fb409);
    n = 0;
    do begin
      wb(0, OFS_STAT, 0);
      n++;
    end while (q[15:12] === 4'h0 && n < 200);
    wb(0, OFS_QUEUE, 0); chk("received", 32'hffffffff, q);
    wb(1, OFS_CTRL, 32'h000f3400);
    ones <= 1'b0;
    $display("test receive done");
  endtask : t_rx
  task automatic t_slave;
    int n, m;
    logic p;
    ones  <= 1'b1;
    slave <= 1'b1;
    wb(1, OFS_CLK, 32'h00000018); wb(1, OFS_CTRL, 32'h000f3480); wb(1, OFS_CTRL, 32'h000fb419);
    n = 0;
    m = 0;
    p = mco;
    repeat (200) begin
      @(posedge clk_i);
      m += (mco != p);
      p = mco;
    end
    chk("external master clock", 32'h32, m);
    chk("slave pins", 32'h0, {30'h0, bcoe, wsoe});
    do begin
      wb(0, OFS_STAT, 0);
      n++;
    end while (q[15:12] === 4'h0 && n < 200);
    wb(0, OFS_QUEUE, 0); chk("slave received", 32'hffffffff, q);
    wb(1, OFS_CTRL, 32'h000f3400);
    {ones, slave} <= 2'b00;
    $display("test slave done");
  endtask : t_slave
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_queue();
    t_tx();
    t_rx();
    t_slave();
    give_verdict();
  end
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule : test_audio_serial_port_controller
`default_nettype wire
